// File: rtl/serdes_lane_debug_status_pkg.sv
// Purpose: Shared constants for the lane debug and status register bank.
// Assumes: Byte-wide register port, byte addresses as printed.
// Notes: Counts are little tables decoded in the bank itself.
package serdes_lane_debug_status_pkg;

    localparam int ADDR_W = 12;
    localparam int NUM_LANES = 16;
    localparam int LANE_IDX_W = 4;
    localparam int VOLT_W = 6;
    localparam int COUNT_W = 16;
    localparam int PHASE_W = 8;
    localparam int CODE_W = 4;
    localparam int VOTES_W = 9;

    // Byte addresses.
    localparam logic [11:0] VOLT_RESULT_BASE = 12'h200;
    localparam logic [11:0] MISMATCH_BASE = 12'h210;
    localparam logic [11:0] MISMATCH_LAST = 12'h22f;
    localparam logic [11:0] LOSS_THRESHOLD_ADDR = 12'h234;
    localparam logic [11:0] VOTE_SIZE_ADDR = 12'h235;
    localparam logic [11:0] FREEZE_ADDR = 12'h238;
    localparam logic [11:0] PHASE_ADDR = 12'h239;

    // Field positions.
    localparam int VOLT_LSB = 0;
    localparam int CODE_LSB = 0;
    localparam int FREEZE_BIT = 0;

    // Reset values.
    localparam logic [3:0] LOSS_THRESHOLD_RESET = 4'h8;
    localparam logic [3:0] VOTE_SIZE_RESET = 4'h0;
    localparam logic FREEZE_RESET = 1'b0;

    // Lowest usable loss threshold code and its step in millivolts.
    localparam logic [3:0] LOSS_THRESHOLD_MIN = 4'h2;
    localparam int LOSS_STEP_MV = 15;

    // Equalizer vote size codes.
    localparam logic [3:0] VOTE_CODE_DEFAULT = 4'h0;
    localparam logic [3:0] VOTE_CODE_MIN = 4'h2;
    localparam logic [3:0] VOTE_CODE_MAX = 4'h9;
    localparam logic [8:0] VOTES_DEFAULT = 9'h1ff;

endpackage : serdes_lane_debug_status_pkg

// File: rtl/serdes_lane_debug_status.sv
// Purpose: Register bank that shows eye-scan results, loss-of-signal and equalizer
//          settings, and the phase tracking freeze with its phase read-back.
// Assumes: Lane logic supplies results, completion flags and binary phase on clk_sys_in.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps

module serdes_lane_debug_status #(
    parameter int NUM_LANES = serdes_lane_debug_status_pkg::NUM_LANES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [serdes_lane_debug_status_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Lane eye-scan results
    input wire logic [NUM_LANES-1:0] scan_done_in,
    input wire logic [NUM_LANES*serdes_lane_debug_status_pkg::VOLT_W-1:0] scan_volt_in,
    input wire logic [NUM_LANES*serdes_lane_debug_status_pkg::COUNT_W-1:0] scan_count_in,
    output logic [NUM_LANES-1:0] scan_complete_flag_out,
    // Phase tracking
    input wire logic [serdes_lane_debug_status_pkg::LANE_IDX_W-1:0] lane_debug_select_in,
    input wire logic [NUM_LANES*serdes_lane_debug_status_pkg::PHASE_W-1:0] lane_phase_bin_in,
    output logic phase_track_freeze_out,
    // Loss of signal and equalizer
    input wire logic signal_loss_detect_enable_in,
    output logic [serdes_lane_debug_status_pkg::CODE_W-1:0] signal_loss_threshold_out,
    output logic signal_loss_threshold_valid_out,
    output logic [serdes_lane_debug_status_pkg::VOTES_W-1:0] equalizer_votes_out
);

    localparam int VW = serdes_lane_debug_status_pkg::VOLT_W;
    localparam int CW = serdes_lane_debug_status_pkg::COUNT_W;
    localparam int PW = serdes_lane_debug_status_pkg::PHASE_W;
    localparam int AW = serdes_lane_debug_status_pkg::ADDR_W;
    localparam int KW = serdes_lane_debug_status_pkg::CODE_W;
    localparam int VL = serdes_lane_debug_status_pkg::VOLT_LSB;

    // Offset of an address from a base, kept at the full address width.
    function automatic logic [AW-1:0] addr_offset(input logic [AW-1:0] addr,
                                                  input logic [AW-1:0] base);
        addr_offset = addr - base;
    endfunction : addr_offset

    // Votes needed before the equalizer changes gain.
    function automatic logic [8:0] votes_from_code(input logic [3:0] code);
        logic [9:0] ones;
        ones = 10'h000;
        if (code == serdes_lane_debug_status_pkg::VOTE_CODE_DEFAULT) begin
            votes_from_code = serdes_lane_debug_status_pkg::VOTES_DEFAULT;
        end else begin
            ones = (10'h001 << (code - serdes_lane_debug_status_pkg::VOTE_CODE_MIN + 4'h1));
            votes_from_code = 9'(ones - 10'h001);
        end
    endfunction : votes_from_code

    // Vote codes with a defined count: 0, and 2 to 9.
    function automatic logic vote_code_ok(input logic [3:0] code);
        vote_code_ok = (code == serdes_lane_debug_status_pkg::VOTE_CODE_DEFAULT) ||
                       ((code >= serdes_lane_debug_status_pkg::VOTE_CODE_MIN) &&
                        (code <= serdes_lane_debug_status_pkg::VOTE_CODE_MAX));
    endfunction : vote_code_ok

    // Threshold codes below the lowest step have no defined detector level.
    function automatic logic thr_code_ok(input logic [3:0] code);
        thr_code_ok = (code >= serdes_lane_debug_status_pkg::LOSS_THRESHOLD_MIN);
    endfunction : thr_code_ok

    // Binary to Gray. Neighbouring phase steps then differ in one bit only,
    // so a value caught while the phase moves is off by one step at most.
    function automatic logic [PW-1:0] gray_of(input logic [PW-1:0] bin);
        gray_of = bin ^ (bin >> 1);
    endfunction : gray_of

    // One byte of a mismatch count. The high byte sits at the even address,
    // so software that reads upward sees the count most significant first.
    function automatic logic [7:0] count_byte(input logic [CW-1:0] count,
                                              input logic low_half);
        if (low_half) begin
            count_byte = count[7:0];
        end else begin
            count_byte = count[CW-1:CW-8];
        end
    endfunction : count_byte

    logic [KW-1:0] loss_threshold_q;
    logic [KW-1:0] vote_size_q;
    logic freeze_q;
    logic [PW-1:0] phase_gray_q;
    logic [NUM_LANES-1:0] done_q;
    logic [VW-1:0] volt_q [NUM_LANES];
    logic [CW-1:0] count_q [NUM_LANES];
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [AW-1:0] volt_off;
    logic [AW-1:0] count_off;
    logic [PW-1:0] phase_sel_bin;
    // Decoded vote count as the equalizer sees it.
    logic [serdes_lane_debug_status_pkg::VOTES_W-1:0] votes_q;
    // Address hits.
    logic volt_hit;
    logic count_hit;
    logic thr_hit;
    logic vote_hit;
    logic freeze_hit;
    logic phase_hit;
    // Write qualifiers.
    logic thr_wr;
    logic vote_wr;
    logic freeze_wr;
    logic [KW-1:0] wr_code;

    // Result capture. Results carry no reset value on purpose: they are only
    // meaningful once the matching completion bit reads 1. Each result is taken
    // on the one cycle in which its lane first reports done, so later wander on
    // the lane inputs cannot disturb a value that software is about to read.
    // A lane that drops done and raises it again captures a fresh result.
    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++) begin : g_volt
            always_ff @(posedge clk_sys_in) begin
                if (scan_done_in[g] && !done_q[g]) begin
                    volt_q[g] <= scan_volt_in[g*VW +: VW];
                end
            end
        end
        for (g = 0; g < NUM_LANES; g++) begin : g_count
            always_ff @(posedge clk_sys_in) begin
                if (scan_done_in[g] && !done_q[g]) begin
                    count_q[g] <= scan_count_in[g*CW +: CW];
                end
            end
        end
    endgenerate

    // Completion flags follow the lane level one cycle late. This lines them up
    // with the capture above: a flag never reads 1 before its result is held,
    // which is the order software relies on.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            done_q <= '0;
        end else begin
            done_q <= scan_done_in;
        end
    end

    assign scan_complete_flag_out = done_q;

    // Address hits, decoded once and shared by the write and read paths so the
    // two can never disagree about where a register sits.
    assign volt_hit = (reg_addr_in >= serdes_lane_debug_status_pkg::VOLT_RESULT_BASE) &&
                      (reg_addr_in < serdes_lane_debug_status_pkg::MISMATCH_BASE);
    assign count_hit = (reg_addr_in >= serdes_lane_debug_status_pkg::MISMATCH_BASE) &&
                       (reg_addr_in <= serdes_lane_debug_status_pkg::MISMATCH_LAST);
    assign thr_hit = (reg_addr_in == serdes_lane_debug_status_pkg::LOSS_THRESHOLD_ADDR);
    assign vote_hit = (reg_addr_in == serdes_lane_debug_status_pkg::VOTE_SIZE_ADDR);
    assign freeze_hit = (reg_addr_in == serdes_lane_debug_status_pkg::FREEZE_ADDR);
    assign phase_hit = (reg_addr_in == serdes_lane_debug_status_pkg::PHASE_ADDR);
    assign thr_wr = reg_wr_en_in && thr_hit;
    assign vote_wr = reg_wr_en_in && vote_hit;
    assign freeze_wr = reg_wr_en_in && freeze_hit;
    assign wr_code = reg_wdata_in[serdes_lane_debug_status_pkg::CODE_LSB +: KW];

    // Writable settings. Reserved codes are refused and the old code kept, so
    // the lanes never run with a setting that has no defined meaning.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            loss_threshold_q <= serdes_lane_debug_status_pkg::LOSS_THRESHOLD_RESET;
        end else if (thr_wr && thr_code_ok(wr_code)) begin
            loss_threshold_q <= wr_code;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            vote_size_q <= serdes_lane_debug_status_pkg::VOTE_SIZE_RESET;
        end else if (vote_wr && vote_code_ok(wr_code)) begin
            vote_size_q <= wr_code;
        end
    end

    // Only bit 0 is kept; the upper bits are reserved and read back as zero.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            freeze_q <= serdes_lane_debug_status_pkg::FREEZE_RESET;
        end else if (freeze_wr) begin
            freeze_q <= reg_wdata_in[serdes_lane_debug_status_pkg::FREEZE_BIT];
        end
    end

    // The decoded vote count has its own flop, loaded by the same accepted
    // write as the code, so the equalizer sees a registered value.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            votes_q <= serdes_lane_debug_status_pkg::VOTES_DEFAULT;
        end else if (vote_wr && vote_code_ok(wr_code)) begin
            votes_q <= votes_from_code(wr_code);
        end
    end

    assign phase_track_freeze_out = freeze_q;
    assign signal_loss_threshold_out = loss_threshold_q;
    // The threshold only steers the detector while detection is switched on.
    assign signal_loss_threshold_valid_out = signal_loss_detect_enable_in;
    assign equalizer_votes_out = votes_q;

    // Phase snapshot. While frozen the snapshot holds, so a read under freeze
    // returns the same value even if the select or the lane input wobbles.
    // With the freeze clear, the value read is one cycle old; that is harmless
    // for a status byte that software reads at leisure.
    assign phase_sel_bin = lane_phase_bin_in[lane_debug_select_in*PW +: PW];

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            phase_gray_q <= '0;
        end else if (!freeze_q) begin
            phase_gray_q <= gray_of(phase_sel_bin);
        end
    end

    // Read decode.
    assign volt_off = addr_offset(reg_addr_in, serdes_lane_debug_status_pkg::VOLT_RESULT_BASE);
    assign count_off = addr_offset(reg_addr_in, serdes_lane_debug_status_pkg::MISMATCH_BASE);

    // Only the low bits of an offset pick a lane; the range hits above keep an
    // address from aliasing onto a lane that it does not belong to.
    always_comb begin
        rdata_d = 8'h00;
        if (volt_hit) begin
            if (volt_off < AW'(NUM_LANES)) begin
                rdata_d[VL +: VW] = volt_q[volt_off[3:0]];
            end
        end else if (count_hit) begin
            rdata_d = count_byte(count_q[count_off[4:1]], count_off[0]);
        end else if (thr_hit) begin
            rdata_d[KW-1:0] = loss_threshold_q;
        end else if (vote_hit) begin
            rdata_d[KW-1:0] = vote_size_q;
        end else if (freeze_hit) begin
            rdata_d[serdes_lane_debug_status_pkg::FREEZE_BIT] = freeze_q;
        end else if (phase_hit) begin
            rdata_d = phase_gray_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    // Read data is held until the next read, so a slow master may pick it up
    // late; only the valid strobe is a one-cycle pulse.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_en_in) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_en_in;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;

endmodule : serdes_lane_debug_status

// File: dv/serdes_lane_debug_status_asserts.sv
// Purpose: Port-level timing checks for the lane debug register bank.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Only the register port and the shared settings are watched.
`timescale 1ns/1ps
module serdes_lane_debug_status_asserts (
    // Clock, reset and register port
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rvalid_out,
    // Shared settings
    input wire logic phase_track_freeze_out,
    input wire logic signal_loss_detect_enable_in,
    input wire logic signal_loss_threshold_valid_out,
    input wire logic [3:0] signal_loss_threshold_out,
    input wire logic [8:0] equalizer_votes_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic wr_thr, wr_vote, wr_frz;
    logic [3:0] code;
    assign wr_thr = reg_wr_en_in && reg_addr_in == 12'h234;
    assign wr_vote = reg_wr_en_in && reg_addr_in == 12'h235;
    assign wr_frz = reg_wr_en_in && reg_addr_in == 12'h238;
    assign code = reg_wdata_in[3:0];
    property p_rd_ans; reg_rd_en_in |=> reg_rvalid_out; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_one; !reg_rd_en_in |=> !reg_rvalid_out; endproperty
    a_rd_one: assert property (p_rd_one) else $error("stray read valid");
    property p_frz_set; wr_frz && reg_wdata_in[0] |=> phase_track_freeze_out; endproperty
    a_frz_set: assert property (p_frz_set) else $error("freeze not set");
    property p_frz_hold; !wr_frz |=> $stable(phase_track_freeze_out); endproperty
    a_frz_hold: assert property (p_frz_hold) else $error("freeze moved");
    property p_thr_set;
        wr_thr && code >= 4'h2 |=> signal_loss_threshold_out == $past(code);
    endproperty
    a_thr_set: assert property (p_thr_set) else $error("threshold not stored");
    property p_thr_bad; wr_thr && code < 4'h2 |=> $stable(signal_loss_threshold_out); endproperty
    a_thr_bad: assert property (p_thr_bad) else $error("bad threshold taken");
    property p_thr_en; signal_loss_threshold_valid_out == signal_loss_detect_enable_in; endproperty
    a_thr_en: assert property (p_thr_en) else $error("threshold enable wrong");
    property p_vote_set;
        wr_vote && code inside {[2:9]} ##1 1'b1
            |-> equalizer_votes_out == (9'h001 << ($past(code) - 4'h1)) - 9'h001;
    endproperty
    a_vote_set: assert property (p_vote_set) else $error("vote count wrong");
    property p_vote_bad;
        wr_vote && (code == 4'h1 || code > 4'h9) |=> $stable(equalizer_votes_out);
    endproperty
    a_vote_bad: assert property (p_vote_bad) else $error("reserved vote taken");
    c_frz_rd: cover property (reg_rd_en_in && reg_addr_in == 12'h239 && phase_track_freeze_out);
    c_thr_bad: cover property (wr_thr && code < 4'h2);
    c_vote: cover property (wr_vote && code == 4'h9);
endmodule : serdes_lane_debug_status_asserts

bind serdes_lane_debug_status serdes_lane_debug_status_asserts i_serdes_lane_debug_status_asserts (
    .clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wr_en_in, .reg_rd_en_in, .reg_wdata_in,
    .reg_rvalid_out, .phase_track_freeze_out, .signal_loss_detect_enable_in,
    .signal_loss_threshold_valid_out, .signal_loss_threshold_out, .equalizer_votes_out);

// File: dv/lane_phy_model.sv
// Purpose: Behavioural lane front end giving scan results and lane phases.
// Assumes: After start, one more lane finishes its scan each cycle.
// Notes: Results wander until done, so a capture taken too early shows up.
`timescale 1ns/1ps
module lane_phy_model (
    // Control
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic pause_in,
    // Lane outputs
    output logic [15:0] scan_done_out,
    output logic [95:0] scan_volt_out,
    output logic [255:0] scan_count_out,
    output logic [127:0] lane_phase_bin_out
);
    logic [7:0] tick_q;
    logic [4:0] seq_q;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tick_q <= 8'h00;
            seq_q <= 5'h00;
        end else begin
            if (!pause_in) tick_q <= tick_q + 8'h01;
            if (start_in && seq_q != 5'h10) seq_q <= seq_q + 5'h01;
        end
    end
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            scan_done_out[n] = seq_q > 5'(n);
            scan_volt_out[6*n +: 6] = scan_done_out[n] ? 6'(3*n+1) : ~tick_q[5:0];
            scan_count_out[16*n +: 16] =
                scan_done_out[n] ? {4'(n), 4'h9, ~4'(n), 4'h6} : {2{tick_q}};
            lane_phase_bin_out[8*n +: 8] = tick_q + 8'(17*n);
        end
    end
endmodule : lane_phy_model

// File: dv/serdes_lane_debug_status_test.sv
// Purpose: Self-checking bench for the lane debug register bank.
// Assumes: Byte register port answering a read one cycle after the strobe.
// Notes: Phase reads other than the frozen one pause the lane model so the expected Gray value is exact.
`timescale 1ns/1ps
module serdes_lane_debug_status_test;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0;
    logic start = 1'b0, pause = 1'b0, signal_loss_detect_enable = 1'b0, rvalid, frz, thr_valid;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00, rdata;
    logic [3:0] sel = 4'h0, thr;
    logic [8:0] votes;
    logic [15:0] done, flags;
    logic [95:0] volt;
    logic [255:0] cnt;
    logic [127:0] ph;
    int mismatches = 0, total_checks = 0;
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    lane_phy_model i_lane_phy_model (.clk_sys_in, .rst_n_in, .start_in(start), .pause_in(pause),
        .scan_done_out(done), .scan_volt_out(volt), .scan_count_out(cnt), .lane_phase_bin_out(ph));
    serdes_lane_debug_status i_serdes_lane_debug_status (.clk_sys_in, .rst_n_in,
        .reg_addr_in(addr), .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .scan_done_in(done), .scan_volt_in(volt),
        .scan_count_in(cnt), .scan_complete_flag_out(flags), .lane_debug_select_in(sel),
        .lane_phase_bin_in(ph), .phase_track_freeze_out(frz),
        .signal_loss_detect_enable_in(signal_loss_detect_enable), .signal_loss_threshold_out(thr),
        .signal_loss_threshold_valid_out(thr_valid), .equalizer_votes_out(votes));
    function automatic logic [7:0] gray(input logic [7:0] b);
        return b ^ (b >> 1);
    endfunction : gray
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        total_checks++;
        if (got !== e) begin
            $display("[FAIL] %s expected %h seen %h", what, e, got);
            mismatches++;
        end
    endtask : chk
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1;
        chk("rvalid", 16'h1, {15'h0, rvalid});
        chk(what, {8'h0, e}, {8'h0, rdata});
    endtask : rchk
    task automatic t_reset;
        rchk("thr", 12'h234, 8'h08);
        rchk("votes", 12'h235, 8'h00);
        rchk("freeze", 12'h238, 8'h00);
        chk("votes_out", 16'h1ff, {7'h0, votes});
        chk("flags", 16'h0, flags);
        chk("thr_valid", 16'h0, {15'h0, thr_valid});
        $display("test reset done");
    endtask : t_reset
    task automatic t_scan;
        @(posedge clk_sys_in);
        start <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        #1;
        chk("flags", 16'hffff, flags);
        for (int n = 0; n < 16; n++) begin
            rchk("volt", 12'h200 + 12'(n), 8'(3*n+1));
            rchk("cnt_hi", 12'h210 + 12'(2*n), {4'(n), 4'h9});
            rchk("cnt_lo", 12'h211 + 12'(2*n), {~4'(n), 4'h6});
        end
        wr_reg(12'h203, 8'hff);
        rchk("ro", 12'h203, 8'h0a);
        rchk("unmapped", 12'h230, 8'h00);
        $display("test scan done");
    endtask : t_scan
    task automatic t_thr;
        for (int c = 15; c >= 0; c--) begin
            wr_reg(12'h234, 8'hf0 | 8'(c));
            chk("thr_out", 16'(c < 2 ? 2 : c), {12'h0, thr});
        end
        rchk("thr", 12'h234, 8'h02);
        @(posedge clk_sys_in);
        signal_loss_detect_enable <= 1'b1;
        #1;
        chk("thr_valid", 16'h1, {15'h0, thr_valid});
        $display("test threshold done");
    endtask : t_thr
    task automatic t_votes;
        logic [8:0] e;
        e = 9'h1ff;
        for (int c = 0; c < 16; c++) begin
            if (c == 0) e = 9'h1ff;
            else if (c >= 2 && c <= 9) e = 9'((1 << (c - 1)) - 1);
            wr_reg(12'h235, 8'(c));
            chk("votes_out", {7'h0, e}, {7'h0, votes});
        end
        rchk("votes", 12'h235, 8'h09);
        $display("test votes done");
    endtask : t_votes
    task automatic t_phase;
        logic [7:0] g;
        @(posedge clk_sys_in);
        pause <= 1'b1;
        for (int n = 0; n < 16; n += 5) begin
            @(posedge clk_sys_in);
            sel <= 4'(n);
            repeat (2) @(posedge clk_sys_in);
            g = gray(ph[8*n +: 8]);
            rchk("phase", 12'h239, g);
        end
        wr_reg(12'h238, 8'hfd);
        @(posedge clk_sys_in);
        pause <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        rchk("frozen", 12'h239, g);
        rchk("freeze", 12'h238, 8'h01);
        wr_reg(12'h238, 8'h00);
        @(posedge clk_sys_in);
        pause <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rchk("resumed", 12'h239, gray(ph[127:120]));
        $display("test phase done");
    endtask : t_phase
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_scan;
        t_thr;
        t_votes;
        t_phase;
        end_of_test;
    end
    // The whole run needs well under a thousand cycles; this bound leaves ample margin.
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        mismatches++;
        end_of_test;
    end
endmodule : serdes_lane_debug_status_test
